// ---- inc/ntb_msi_pkg.sv ----
// Package: offsets, fields, reset values and carriers of the bridge register bank
package ntb_msi_pkg;

	localparam logic [11:0] OFF_CAP_CTRL = 12'h064;
	localparam logic [11:0] OFF_ADDR_LO = 12'h068;
	localparam logic [11:0] OFF_ADDR_HI = 12'h06c;
	localparam logic [11:0] OFF_MSG_DATA = 12'h070;
	localparam logic [11:0] OFF_CAP_HDR = 12'h074;
	localparam logic [11:0] OFF_CTRL = 12'h078;
	localparam logic [11:0] OFF_STATUS = 12'h079;

	localparam int CAP_EN_BIT = 16;
	localparam int CAP_MMC_LSB = 17;
	localparam int CAP_MME_LSB = 20;
	localparam int CAP_WIDE_BIT = 23;
	localparam logic [2:0] ONE_MESSAGE = 3'h0;
	localparam logic [15:0] CAP_LOW_HALF = 16'h7405;

	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_PROT_BIT = 2;
	localparam int CTL_RESET_ACTION_ENABLE_BIT = 3;
	localparam int CTL_RA_BIT = 4;
	localparam int CTL_PROPAGATE_BRIDGE_RESET_BIT = 5;
	localparam int CTL_RST_BIT = 7;

	localparam int ST_FAR_FUND = 0;
	localparam int ST_FAR_HOT = 1;
	localparam int ST_FAR_RIP = 2;
	localparam int ST_FWD_MISS = 3;
	localparam int ST_REV_MISS = 4;
	localparam int ST_TBL_ERR = 5;
	localparam int ST_ECRC = 6;
	localparam int ST_WIN_MISS = 7;

	localparam logic [7:0] RST_CAP_ID = 8'h09;
	localparam logic [7:0] RST_NEXT_PTR = 8'hb4;
	localparam logic [7:0] RST_CAP_LEN = 8'h40;
	localparam logic [7:0] RST_CAP_TYPE = 8'h01;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		MODE_ENABLED = 2'h0,
		MODE_NOT_READY = 2'h1,
		MODE_DISABLED = 2'h2,
		MODE_RESERVED = 2'h3
	} side_mode_t;

	typedef struct packed {
		logic wide;
		logic [63:0] addr;
		logic [15:0] payload;
	} msi_msg_t;

	typedef struct packed {
		logic forward_table_miss;
		logic reverse_table_miss;
		logic table_access;
		logic table_index_valid;
		logic crc_fault;
		logic crc_consumed;
		logic window_miss;
	} rx_events_t;

endpackage

// ---- rtl/ntb_msi_control_status.sv ----
// Bridge register bank: interrupt capability, address/data, capability header, control and status
`timescale 1ns/1ps

// Behaviour
// RL1: Interrupts are sent only while capability enable bit 16 is one.
// RL2: Capability reads one message in both count fields and bit 23 set.
// RL3: Lower address holds bits 31:2; bits 1:0 read zero, ignore writes.
// RL4: Nonzero upper address selects a 64-bit interrupt write, else 32-bit.
// RL5: Interrupt write carries 16-bit payload; data bits 31:16 read zero.
// RL6: Capability header resets to 0x9, 0xB4, 0x40, 0x1; fields writable.
// RL7: Mode decodes 0 enabled, 1 not ready, 2 disabled, 3 reserved.
// RL8: Not ready: far config requests get retry, other far traffic ignored.
// RL9: Disabled: far traffic discarded with credits returned; outbound continues.
// RL10: If both sides block, the side that blocked first returns to enabled.
// RL11: Mode resets 0 external, 1 internal; only internal resets touch it.
// RL12: Protect bit: far writes to capability ignored, far reads return zero.
// RL13: Internal side applies reset action on far reset; external reads zero.
// RL14: Non-transparent mode with bit 5: bridge reset input resets whole device.
// RL15: Writing one to control bit 7 resets the device; reads zero.
// RL16: Far fundamental and hot reset flags set on detection, clear on one.
// RL17: Reset-in-progress flag follows far reset; software avoids access then.
// RL18: Forward and reverse table misses set status bits 3 and 4.
// RL19: Table data access with invalid index sets status bit 5.
// RL20: Crc fault on forwarded packet sets bit 6; window miss sets 7.
// RL21: Control bits 2-5 and flags except 0 survive non-internal-fundamental resets.
// RL22: Byte enables keep control and status bytes independent.
module ntb_msi_control_status
	import ntb_msi_pkg::*;
#(
	parameter bit IS_INTERNAL = 1'b1
)(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic int_hot_rst_i,
	input wire logic ext_fund_rst_i,
	input wire logic ext_hot_rst_i,
	input wire logic cfg_req_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_far_i,
	input wire logic [11:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic cfg_ack_o,
	output logic [31:0] cfg_rdata_o,
	input wire logic msi_req_i,
	output logic msi_send_o,
	output msi_msg_t msi_msg_o,
	input wire logic far_rx_valid_i,
	input wire logic far_rx_is_cfg_i,
	output logic far_rx_pass_o,
	output logic far_rx_retry_o,
	output logic far_rx_drop_o,
	output logic far_rx_credit_o,
	output logic near_tx_allow_o,
	input wire logic [1:0] peer_mode_i,
	input wire logic peer_force_not_ready_i,
	output logic force_peer_not_ready_o,
	output logic [1:0] opposite_side_mode_o,
	input wire logic far_fund_rst_i,
	input wire logic far_hot_rst_i,
	input wire rx_events_t rx_events_i,
	input wire logic bridge_reset_input_n_i,
	input wire logic nt_mode_i,
	output logic device_reset_o
);

	// Far-side and pin levels cross into the core clock here
	logic [1:0] sync_fund_q, sync_hot_q, sync_brst_q, sync_nt_q;
	logic [1:0] sync_ifh_q, sync_efr_q, sync_ehr_q;
	logic fund_seen_q, hot_seen_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync_fund_q <= 2'h0;
			sync_hot_q <= 2'h0;
			sync_brst_q <= 2'h3;
			sync_nt_q <= 2'h0;
			sync_ifh_q <= 2'h0;
			sync_efr_q <= 2'h0;
			sync_ehr_q <= 2'h0;
			fund_seen_q <= 1'b0;
			hot_seen_q <= 1'b0;
		end
		else
		begin
			sync_fund_q <= {sync_fund_q[0], far_fund_rst_i};
			sync_hot_q <= {sync_hot_q[0], far_hot_rst_i};
			sync_brst_q <= {sync_brst_q[0], bridge_reset_input_n_i};
			sync_nt_q <= {sync_nt_q[0], nt_mode_i};
			sync_ifh_q <= {sync_ifh_q[0], int_hot_rst_i};
			sync_efr_q <= {sync_efr_q[0], ext_fund_rst_i};
			sync_ehr_q <= {sync_ehr_q[0], ext_hot_rst_i};
			fund_seen_q <= sync_fund_q[1];
			hot_seen_q <= sync_hot_q[1];
		end
	end

	logic far_fund_rise, far_hot_rise, far_reset_rise, far_in_reset;
	logic int_hot, ext_fund, ext_hot, soft_rst;
	assign far_fund_rise = sync_fund_q[1] && !fund_seen_q;
	assign far_hot_rise = sync_hot_q[1] && !hot_seen_q;
	assign far_reset_rise = far_fund_rise || far_hot_rise;
	assign far_in_reset = sync_fund_q[1] || sync_hot_q[1];
	assign int_hot = sync_ifh_q[1];
	assign ext_fund = sync_efr_q[1];
	assign ext_hot = sync_ehr_q[1];
	assign soft_rst = int_hot || ext_fund || ext_hot;

	// Access decode; far accesses to the capability are fenced by the protect bit
	logic wr, rd_hit, hdr_sel, ctl_sel, protect_hit, wr_ok;
	logic prot_q;
	assign hdr_sel = cfg_addr_i == OFF_CAP_HDR;
	assign ctl_sel = cfg_addr_i == OFF_CTRL;
	assign protect_hit = cfg_far_i && prot_q && (hdr_sel || ctl_sel);
	assign wr = cfg_req_i && cfg_wr_i;
	assign wr_ok = wr && !protect_hit; // [RL12]
	assign rd_hit = cfg_req_i && !cfg_wr_i;

	logic en_q;
	logic [31:2] addr_lo_q;
	logic [31:0] addr_hi_q;
	logic [15:0] payload_q;
	logic [31:0] hdr_q;
	logic rst_cmd_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			en_q <= 1'b0;
			addr_lo_q <= 30'h0000_0000;
			addr_hi_q <= RST_ZERO;
			payload_q <= 16'h0000;
			hdr_q <= {RST_CAP_TYPE, RST_CAP_LEN, RST_NEXT_PTR, RST_CAP_ID}; // [RL6]
		end
		else if (soft_rst)
		begin
			en_q <= 1'b0;
			addr_lo_q <= 30'h0000_0000;
			addr_hi_q <= RST_ZERO;
			payload_q <= 16'h0000;
			hdr_q <= {RST_CAP_TYPE, RST_CAP_LEN, RST_NEXT_PTR, RST_CAP_ID}; // [RL6]
		end
		else if (wr_ok)
		begin
			if (cfg_addr_i == OFF_CAP_CTRL && cfg_be_i[2])
				en_q <= cfg_wdata_i[CAP_EN_BIT]; // [RL1]
			if (cfg_addr_i == OFF_ADDR_LO)
			begin
				if (cfg_be_i[0])
					addr_lo_q[7:2] <= cfg_wdata_i[7:2]; // [RL3]
				for (int b = 1; b < 4; b++)
					if (cfg_be_i[b])
						addr_lo_q[b*8 +: 8] <= cfg_wdata_i[b*8 +: 8];
			end
			for (int b = 0; b < 4; b++)
			begin
				if (cfg_addr_i == OFF_ADDR_HI && cfg_be_i[b])
					addr_hi_q[b*8 +: 8] <= cfg_wdata_i[b*8 +: 8];
				if (hdr_sel && cfg_be_i[b])
					hdr_q[b*8 +: 8] <= cfg_wdata_i[b*8 +: 8]; // [RL6]
			end
			for (int b = 0; b < 2; b++)
				if (cfg_addr_i == OFF_MSG_DATA && cfg_be_i[b])
					payload_q[b*8 +: 8] <= cfg_wdata_i[b*8 +: 8]; // [RL5]
		end
	end

	// Sticky control bits survive all but the internal fundamental reset
	logic reset_action_enable_q, ra_q, propagate_bridge_reset_q;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prot_q <= 1'b0;
			reset_action_enable_q <= 1'b0;
			ra_q <= 1'b0;
			propagate_bridge_reset_q <= 1'b0;
		end
		else if (wr_ok && ctl_sel && cfg_be_i[0]) // [RL22]
		begin
			prot_q <= cfg_wdata_i[CTL_PROT_BIT]; // [RL21]
			reset_action_enable_q <= IS_INTERNAL && cfg_wdata_i[CTL_RESET_ACTION_ENABLE_BIT]; // [RL13]
			ra_q <= IS_INTERNAL && cfg_wdata_i[CTL_RA_BIT]; // [RL13]
			propagate_bridge_reset_q <= cfg_wdata_i[CTL_PROPAGATE_BRIDGE_RESET_BIT];
		end
	end

	// Device reset request is a one-cycle strobe; the bit itself never reads back
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rst_cmd_q <= 1'b0;
		else
			rst_cmd_q <= wr_ok && ctl_sel && cfg_be_i[0] && cfg_wdata_i[CTL_RST_BIT]; // [RL15]
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			device_reset_o <= 1'b0;
		else
			device_reset_o <= rst_cmd_q || (propagate_bridge_reset_q && sync_nt_q[1] && !sync_brst_q[1]); // [RL14] [RL15]
	end

	// Opposite-side mode and deadlock breaker
	side_mode_t mode_q;
	logic own_block, peer_block, own_block_q, peer_block_q, act_own, act_peer;
	assign own_block = mode_q == MODE_NOT_READY || mode_q == MODE_DISABLED;
	assign peer_block = peer_mode_i == MODE_NOT_READY || peer_mode_i == MODE_DISABLED;
	assign act_own = IS_INTERNAL && reset_action_enable_q && ra_q && far_reset_rise; // [RL13]
	assign act_peer = IS_INTERNAL && reset_action_enable_q && !ra_q && far_reset_rise; // [RL13]

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			own_block_q <= 1'b0;
			peer_block_q <= 1'b0;
		end
		else
		begin
			own_block_q <= own_block;
			peer_block_q <= peer_block;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			mode_q <= IS_INTERNAL ? MODE_NOT_READY : MODE_ENABLED; // [RL11]
		else if (int_hot)
			mode_q <= IS_INTERNAL ? MODE_NOT_READY : MODE_ENABLED; // [RL11]
		else if (own_block && own_block_q && peer_block && !peer_block_q)
			mode_q <= MODE_ENABLED; // [RL10]
		else if (act_own || peer_force_not_ready_i)
			mode_q <= MODE_NOT_READY; // [RL13]
		else if (wr_ok && ctl_sel && cfg_be_i[0])
			mode_q <= side_mode_t'(cfg_wdata_i[CTL_MODE_LSB +: 2]); // [RL22]
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			force_peer_not_ready_o <= 1'b0;
		else
			force_peer_not_ready_o <= act_peer;
	end

	assign opposite_side_mode_o = mode_q;

	// Far receive path; reserved mode is treated as enabled
	always_comb
	begin
		far_rx_pass_o = 1'b0;
		far_rx_retry_o = 1'b0;
		far_rx_drop_o = 1'b0;
		far_rx_credit_o = 1'b0;
		case (mode_q) // [RL7]
			MODE_NOT_READY:
			begin
				far_rx_retry_o = far_rx_valid_i && far_rx_is_cfg_i; // [RL8]
				far_rx_drop_o = far_rx_valid_i && !far_rx_is_cfg_i; // [RL8]
			end
			MODE_DISABLED:
			begin
				far_rx_drop_o = far_rx_valid_i; // [RL9]
				far_rx_credit_o = far_rx_valid_i; // [RL9]
			end
			default:
				far_rx_pass_o = far_rx_valid_i;
		endcase
	end

	assign near_tx_allow_o = 1'b1; // [RL9]

	// Status flags: a set in the same cycle as a write-one clear wins; the external fundamental reset still clears flag 0 over a set
	logic [7:0] sts_q, sts_set, sts_clr;
	always_comb
	begin
		sts_set = 8'h00;
		sts_set[ST_FAR_FUND] = far_fund_rise; // [RL16]
		sts_set[ST_FAR_HOT] = far_hot_rise; // [RL16]
		sts_set[ST_FWD_MISS] = rx_events_i.forward_table_miss; // [RL18]
		sts_set[ST_REV_MISS] = rx_events_i.reverse_table_miss; // [RL18]
		sts_set[ST_TBL_ERR] = rx_events_i.table_access && !rx_events_i.table_index_valid; // [RL19]
		sts_set[ST_ECRC] = rx_events_i.crc_fault && !rx_events_i.crc_consumed; // [RL20]
		sts_set[ST_WIN_MISS] = rx_events_i.window_miss; // [RL20]
		sts_clr = (wr_ok && ctl_sel && cfg_be_i[1]) ? cfg_wdata_i[15:8] : 8'h00; // [RL22]
		sts_clr[ST_FAR_RIP] = 1'b0;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sts_q <= 8'h00;
		else
		begin
			sts_q <= (sts_q & ~sts_clr) | sts_set; // [RL21]
			sts_q[ST_FAR_RIP] <= far_in_reset; // [RL17]
			if (ext_fund)
				sts_q[ST_FAR_FUND] <= 1'b0; // [RL21]
		end
	end

	// Interrupt message launch
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			msi_send_o <= 1'b0;
			msi_msg_o <= '0;
		end
		else
		begin
			msi_send_o <= msi_req_i && en_q; // [RL1]
			if (msi_req_i && en_q)
			begin
				msi_msg_o.wide <= addr_hi_q != RST_ZERO; // [RL4]
				msi_msg_o.addr <= {addr_hi_q, addr_lo_q, 2'b00}; // [RL4]
				msi_msg_o.payload <= payload_q; // [RL5]
			end
		end
	end

	// Read mux and one-cycle answer
	logic [31:0] rdata;
	always_comb
	begin
		rdata = 32'h0000_0000;
		case (cfg_addr_i)
			OFF_CAP_CTRL:
				rdata = {8'h00, 1'b1, ONE_MESSAGE, ONE_MESSAGE, en_q, CAP_LOW_HALF}; // [RL2]
			OFF_ADDR_LO:
				rdata = {addr_lo_q, 2'b00}; // [RL3]
			OFF_ADDR_HI:
				rdata = addr_hi_q;
			OFF_MSG_DATA:
				rdata = {16'h0000, payload_q}; // [RL5]
			OFF_CAP_HDR:
				rdata = hdr_q;
			OFF_CTRL:
				rdata = {16'h0000, sts_q, 1'b0, 1'b0, propagate_bridge_reset_q, ra_q, reset_action_enable_q, prot_q, mode_q}; // [RL15]
			default:
				rdata = 32'h0000_0000;
		endcase
		if (protect_hit)
			rdata = 32'h0000_0000; // [RL12]
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cfg_ack_o <= 1'b0;
			cfg_rdata_o <= 32'h0000_0000;
		end
		else
		begin
			cfg_ack_o <= cfg_req_i;
			cfg_rdata_o <= rd_hit ? rdata : 32'h0000_0000;
		end
	end

	sequence s_far_fund_edge;
		!fund_seen_q && sync_fund_q[1];
	endsequence

	property p_msi_gate;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		msi_send_o |-> $past(en_q) && $past(msi_req_i);
	endproperty
	a_msi_gate: assert property (p_msi_gate) else $error("interrupt sent while disabled"); // [RL1]

	property p_cap_read;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		rd_hit && cfg_addr_i == OFF_CAP_CTRL ##1 cfg_ack_o |-> cfg_rdata_o[23:17] == 7'h40;
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("capability count or width wrong"); // [RL2]

	property p_addr_low_bits;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		msi_send_o |-> msi_msg_o.addr[1:0] == 2'b00;
	endproperty
	a_addr_low_bits: assert property (p_addr_low_bits) else $error("address low bits not zero"); // [RL3]

	property p_wide;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		msi_send_o |-> msi_msg_o.wide == (msi_msg_o.addr[63:32] != 32'h0000_0000);
	endproperty
	a_wide: assert property (p_wide) else $error("address width selection wrong"); // [RL4]

	property p_retry;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		mode_q == MODE_NOT_READY && far_rx_valid_i |-> !far_rx_pass_o && (far_rx_retry_o == far_rx_is_cfg_i);
	endproperty
	a_retry: assert property (p_retry) else $error("not-ready handling wrong"); // [RL8]

	property p_credit;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		mode_q == MODE_DISABLED && far_rx_valid_i |-> far_rx_drop_o && far_rx_credit_o && !far_rx_pass_o;
	endproperty
	a_credit: assert property (p_credit) else $error("discard without credit"); // [RL9]

	property p_protect;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		rd_hit && protect_hit |=> cfg_rdata_o == 32'h0000_0000;
	endproperty
	a_protect: assert property (p_protect) else $error("protected read leaked data"); // [RL12]

	property p_rst_cmd;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_ok && ctl_sel && cfg_be_i[0] && cfg_wdata_i[CTL_RST_BIT] |-> ##2 device_reset_o;
	endproperty
	a_rst_cmd: assert property (p_rst_cmd) else $error("device reset not started"); // [RL15]

	property p_fund_flag;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_far_fund_edge |=> sts_q[ST_FAR_FUND] || $past(ext_fund);
	endproperty
	a_fund_flag: assert property (p_fund_flag) else $error("far fundamental reset flag missed"); // [RL16]

	property p_rip;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		##1 sts_q[ST_FAR_RIP] == $past(far_in_reset);
	endproperty
	a_rip: assert property (p_rip) else $error("reset in progress flag wrong"); // [RL17]

	property p_ext_zero;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		force_peer_not_ready_o || !IS_INTERNAL |->
			(IS_INTERNAL ? $past(reset_action_enable_q) && !$past(ra_q) : !reset_action_enable_q && !ra_q && !force_peer_not_ready_o);
	endproperty
	a_ext_zero: assert property (p_ext_zero) else $error("external side reset action active"); // [RL13]

endmodule // ntb_msi_control_status

// ---- tb/far_side_model.sv ----
// Far side of the bridge: peer mode register and its deadlock escape
`timescale 1ns/1ps
module far_side_model
	import ntb_msi_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic set_i,
	input wire logic [1:0] mode_i,
	input wire logic force_not_ready_i,
	input wire logic [1:0] near_mode_i,
	output logic [1:0] mode_o,
	output logic force_near_o
);
	logic near_blk_q;
	logic blk;
	logic near_blk;
	assign blk = (mode_o == MODE_NOT_READY) || (mode_o == MODE_DISABLED);
	assign near_blk = (near_mode_i == MODE_NOT_READY) || (near_mode_i == MODE_DISABLED);
	// External side has no reset action of its own
	assign force_near_o = 1'h0;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mode_o <= MODE_ENABLED;
			near_blk_q <= 1'h0;
		end
		else
		begin
			near_blk_q <= near_blk;
			if (set_i)
				mode_o <= mode_i;
			else if (force_not_ready_i)
				mode_o <= MODE_NOT_READY;
			else if (blk && near_blk && !near_blk_q)
				mode_o <= MODE_ENABLED;
		end
	end
endmodule // far_side_model

// ---- tb/test_ntb_msi_control_status.sv ----
// Self-checking bench for the bridge register bank
`timescale 1ns/1ps
module test_ntb_msi_control_status;
	import ntb_msi_pkg::*;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic core_clk_i = 1'h0, rst_n_i = 1'h0, int_hot_rst_i = 1'h0, ext_fund_rst_i = 1'h0, ext_hot_rst_i = 1'h0;
	logic cfg_req_i = 1'h0, cfg_wr_i = 1'h0, cfg_far_i = 1'h0, msi_req_i = 1'h0, pset = 1'h0;
	logic far_rx_valid_i = 1'h0, far_rx_is_cfg_i = 1'h0, far_fund_rst_i = 1'h0, far_hot_rst_i = 1'h0;
	logic bridge_reset_input_n_i = 1'h1, nt_mode_i = 1'h1;
	logic [11:0] cfg_addr_i = 12'h000;
	logic [3:0] cfg_be_i = 4'h0;
	logic [31:0] cfg_wdata_i = 32'h0000_0000;
	logic [1:0] pmode = 2'h0;
	rx_events_t rx_events_i = '0;
	logic cfg_ack_o, msi_send_o, far_rx_pass_o, far_rx_retry_o, far_rx_drop_o, far_rx_credit_o, near_tx_allow_o;
	logic peer_force_not_ready_i, force_peer_not_ready_o, device_reset_o;
	logic [1:0] peer_mode_i, opposite_side_mode_o;
	logic [31:0] cfg_rdata_o;
	msi_msg_t msi_msg_o;
	int mismatches = 0;
	int checked = 0;
	logic [6:0] ev_tab [7] = '{7'h40, 7'h20, 7'h10, 7'h18, 7'h04, 7'h06, 7'h01};
	logic [7:0] ev_exp [7] = '{8'h08, 8'h10, 8'h20, 8'h00, 8'h40, 8'h00, 8'h80};

	ntb_msi_control_status #(.IS_INTERNAL(1'b1)) dut (.core_clk_i, .rst_n_i, .int_hot_rst_i, .ext_fund_rst_i,
		.ext_hot_rst_i, .cfg_req_i, .cfg_wr_i, .cfg_far_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_ack_o,
		.cfg_rdata_o, .msi_req_i, .msi_send_o, .msi_msg_o, .far_rx_valid_i, .far_rx_is_cfg_i, .far_rx_pass_o,
		.far_rx_retry_o, .far_rx_drop_o, .far_rx_credit_o, .near_tx_allow_o, .peer_mode_i, .peer_force_not_ready_i,
		.force_peer_not_ready_o, .opposite_side_mode_o, .far_fund_rst_i, .far_hot_rst_i, .rx_events_i,
		.bridge_reset_input_n_i, .nt_mode_i, .device_reset_o);
	far_side_model peer (.core_clk_i, .rst_n_i, .set_i(pset), .mode_i(pmode), .force_not_ready_i(force_peer_not_ready_o),
		.near_mode_i(opposite_side_mode_o), .mode_o(peer_mode_i), .force_near_o(peer_force_not_ready_i));

	always #25 core_clk_i = ~core_clk_i;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// Request held one cycle; ack and data sampled on the following edge
	task automatic acc(input logic w, input logic f, input logic [11:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk_i);
		cfg_req_i <= 1'h1;
		cfg_wr_i <= w;
		cfg_far_i <= f;
		cfg_addr_i <= a;
		cfg_be_i <= b;
		cfg_wdata_i <= d;
		@(posedge core_clk_i);
		cfg_req_i <= 1'h0;
		#1;
		check("ack", 32'h0000_0001, {31'h0, cfg_ack_o});
		q = cfg_rdata_o;
	endtask
	task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
		logic [31:0] q;
		acc(1'h1, 1'h0, a, b, d, q);
	endtask
	task automatic rd(input string what, input int f, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		acc(1'h0, f[0], a, 4'hf, 32'h0000_0000, q);
		check(what, e, q & m);
	endtask
	task automatic msi(input logic sent, input logic wide, input logic [63:0] a);
		@(posedge core_clk_i);
		msi_req_i <= 1'h1;
		@(posedge core_clk_i);
		msi_req_i <= 1'h0;
		#1;
		check("msi_send", {31'h0, sent}, {31'h0, msi_send_o});
		if (sent)
		begin
			check("msi_wide", {31'h0, wide}, {31'h0, msi_msg_o.wide});
			check("msi_addr_lo", a[31:0], msi_msg_o.addr[31:0]);
			check("msi_addr_hi", a[63:32], msi_msg_o.addr[63:32]);
			check("msi_payload", 32'h0000_abcd, {16'h0, msi_msg_o.payload});
		end
	endtask
	task automatic peer_set(input logic [1:0] m);
		@(posedge core_clk_i);
		pset <= 1'h1;
		pmode <= m;
		@(posedge core_clk_i);
		pset <= 1'h0;
	endtask
	task automatic event_pulse(input logic [6:0] v);
		@(posedge core_clk_i);
		rx_events_i <= rx_events_t'(v);
		@(posedge core_clk_i);
		rx_events_i <= '0;
		cycles(2);
	endtask
	// Device reset is a synchronised path, so allow a few cycles
	task automatic wait_reset(input string what);
		for (int n = 0; n < 8 && device_reset_o !== 1'h1; n++)
			cycles(1);
		check(what, 32'h0000_0001, {31'h0, device_reset_o});
		if (device_reset_o !== 1'h1)
			print_verdict;
	endtask

	initial
	begin
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'h1;
		rd("cap_ctrl", 0, OFF_CAP_CTRL, ALL, 32'h0080_7405);
		rd("addr_lo", 0, OFF_ADDR_LO, ALL, 32'h0000_0000);
		rd("addr_hi", 0, OFF_ADDR_HI, ALL, 32'h0000_0000);
		rd("msg_data", 0, OFF_MSG_DATA, ALL, 32'h0000_0000);
		rd("cap_hdr", 0, OFF_CAP_HDR, ALL, 32'h0140_b409);
		rd("ctrl_status", 0, OFF_CTRL, 32'h0000_ffff, 32'h0000_0001);
		$display("test reset_values finished");
		wr(OFF_CAP_CTRL, 4'hf, ALL);
		rd("cap_ctrl", 0, OFF_CAP_CTRL, ALL, 32'h0081_7405);
		wr(OFF_ADDR_LO, 4'hf, 32'h1234_567b);
		rd("addr_lo", 0, OFF_ADDR_LO, ALL, 32'h1234_5678);
		wr(OFF_MSG_DATA, 4'hf, 32'hffff_abcd);
		rd("msg_data", 0, OFF_MSG_DATA, ALL, 32'h0000_abcd);
		msi(1'h1, 1'h0, 64'h0000_0000_1234_5678);
		wr(OFF_ADDR_HI, 4'hf, 32'h0000_00a5);
		msi(1'h1, 1'h1, 64'h0000_00a5_1234_5678);
		wr(OFF_CAP_CTRL, 4'hf, 32'h0000_0000);
		msi(1'h0, 1'h0, 64'h0000_0000_0000_0000);
		$display("test interrupt finished");
		wr(OFF_CAP_HDR, 4'hf, 32'hdead_beef);
		rd("cap_hdr", 0, OFF_CAP_HDR, ALL, 32'hdead_beef);
		wr(OFF_CTRL, 4'h1, 32'h0000_0004);
		begin
			logic [31:0] q;
			acc(1'h1, 1'h1, OFF_CAP_HDR, 4'hf, 32'h0000_0000, q);
		end
		rd("hdr_near", 0, OFF_CAP_HDR, ALL, 32'hdead_beef);
		rd("hdr_far", 1, OFF_CAP_HDR, ALL, 32'h0000_0000);
		rd("ctrl_far", 1, OFF_CTRL, ALL, 32'h0000_0000);
		rd("ctrl_near", 0, OFF_CTRL, 32'h0000_ffff, 32'h0000_0004);
		$display("test protect finished");
		for (int m = 0; m < 4; m++)
		begin
			wr(OFF_CTRL, 4'h1, 32'(m));
			for (int c = 0; c < 2; c++)
			begin
				@(posedge core_clk_i);
				far_rx_valid_i <= 1'h1;
				far_rx_is_cfg_i <= c[0];
				#1;
				check("pass", 32'((m != 1) && (m != 2)), {31'h0, far_rx_pass_o});
				check("retry", 32'((m == 1) && (c == 1)), {31'h0, far_rx_retry_o});
				check("drop_credit_tx", 32'({m == 2 || (m == 1 && c == 0), m == 2, 1'b1}),
					{29'h0, far_rx_drop_o, far_rx_credit_o, near_tx_allow_o});
			end
			@(posedge core_clk_i);
			far_rx_valid_i <= 1'h0;
		end
		$display("test modes finished");
		wr(OFF_CTRL, 4'h1, 32'h0000_0002);
		peer_set(2'h1);
		cycles(3);
		check("deadlock", 32'h0000_0001, {28'h0, opposite_side_mode_o, peer_mode_i});
		peer_set(2'h0);
		$display("test deadlock finished");
		wr(OFF_CTRL, 4'h1, 32'h0000_0008);
		@(posedge core_clk_i);
		far_fund_rst_i <= 1'h1;
		cycles(5);
		rd("status_rip", 0, OFF_CTRL, 32'h0000_ff00, 32'h0000_0500);
		check("peer_forced", 32'h0000_0001, {30'h0, peer_mode_i});
		@(posedge core_clk_i);
		far_fund_rst_i <= 1'h0;
		cycles(5);
		rd("status_fund", 0, OFF_CTRL, 32'h0000_ff00, 32'h0000_0100);
		wr(OFF_CTRL, 4'h2, 32'h0000_0100);
		rd("w1c", 0, OFF_CTRL, 32'h0000_ffff, 32'h0000_0008);
		peer_set(2'h0);
		wr(OFF_CTRL, 4'h1, 32'h0000_0018);
		@(posedge core_clk_i);
		far_hot_rst_i <= 1'h1;
		cycles(5);
		@(posedge core_clk_i);
		far_hot_rst_i <= 1'h0;
		cycles(5);
		rd("hot_action", 0, OFF_CTRL, 32'h0000_ffff, 32'h0000_0219);
		wr(OFF_CTRL, 4'h2, 32'h0000_ff00);
		$display("test far_reset finished");
		for (int i = 0; i < 7; i++)
		begin
			event_pulse(ev_tab[i]);
			rd("status_event", 0, OFF_CTRL, 32'h0000_ff00, {16'h0, ev_exp[i], 8'h00});
			wr(OFF_CTRL, 4'h2, 32'h0000_ff00);
		end
		$display("test events finished");
		event_pulse(7'h40);
		wr(OFF_CTRL, 4'h1, 32'h0000_002e);
		@(posedge core_clk_i);
		ext_fund_rst_i <= 1'h1;
		cycles(4);
		@(posedge core_clk_i);
		ext_fund_rst_i <= 1'h0;
		cycles(4);
		rd("ext_fund", 0, OFF_CTRL, 32'h0000_ffff, 32'h0000_082e);
		rd("hdr_default", 0, OFF_CAP_HDR, ALL, 32'h0140_b409);
		@(posedge core_clk_i);
		int_hot_rst_i <= 1'h1;
		cycles(4);
		@(posedge core_clk_i);
		int_hot_rst_i <= 1'h0;
		cycles(4);
		rd("int_hot", 0, OFF_CTRL, 32'h0000_ffff, 32'h0000_082d);
		$display("test soft_resets finished");
		wr(OFF_CTRL, 4'h1, 32'h0000_000d);
		@(posedge core_clk_i);
		bridge_reset_input_n_i <= 1'h0;
		cycles(6);
		check("no_propagate", 32'h0000_0000, {31'h0, device_reset_o});
		@(posedge core_clk_i);
		bridge_reset_input_n_i <= 1'h1;
		wr(OFF_CTRL, 4'h1, 32'h0000_002d);
		cycles(6);
		@(posedge core_clk_i);
		bridge_reset_input_n_i <= 1'h0;
		wait_reset("propagate");
		@(posedge core_clk_i);
		bridge_reset_input_n_i <= 1'h1;
		cycles(6);
		wr(OFF_CTRL, 4'h1, 32'h0000_0080);
		wait_reset("soft_device_reset");
		rd("rst_bit", 0, OFF_CTRL, 32'h0000_0080, 32'h0000_0000);
		$display("test device_reset finished");
		print_verdict;
	end
endmodule // test_ntb_msi_control_status
